// ### logic/alim_cfg.svh
`ifndef ALIM_CFG_SVH
`define ALIM_CFG_SVH
// register indices on the plain port
`define ALIM_ADDR_ENV1 4'h0
`define ALIM_ADDR_ENV2 4'h1
`define ALIM_ADDR_ENV3 4'h2
`define ALIM_ADDR_OPERATION_MODE_PRESET 4'h3
`define ALIM_ADDR_CMD 4'h4
`define ALIM_ADDR_SPEED 4'h5
`define ALIM_ADDR_SSTS 4'h6
`define ALIM_ADDR_EXTENDED_STATUS_REGISTER 4'h7
`define ALIM_ADDR_IPS 4'h8
`define ALIM_ADDR_SOFT 4'h9
// field positions
`define ALIM_ENV1_ELM 3
`define ALIM_ENV1_FLTR 26
`define ALIM_ENV2_EZL 23
`define ALIM_ENV3_EZD_LO 4
`define ALIM_OPERATION_MODE_PRESET_CONSTANT_SYNTH_SPEED_ENABLE 15
`define ALIM_OPERATION_MODE_PRESET_IPNEG 16
`define ALIM_CMD_X_AXIS_SELECT 8
`define ALIM_CMD_Y_AXIS_SELECT 9
`define ALIM_SSTS_PEL 12
`define ALIM_SSTS_MEL 13
`define ALIM_EXTENDED_STATUS_REGISTER_EZ 10
// command codes
`define ALIM_CMD_STOP_IMM 8'h49
`define ALIM_CMD_STOP_DEC 8'h4a
`define ALIM_CMD_START_FL 8'h50
`define ALIM_CMD_START_FL2 8'h51
`define ALIM_CMD_START_FH 8'h52
`define ALIM_CMD_START_FH2 8'h53
// operation mode codes
`define ALIM_MOD_TO_PLUS 7'h20
`define ALIM_MOD_TO_MINUS 7'h28
`define ALIM_MOD_OFF_MINUS 7'h22
`define ALIM_MOD_OFF_PLUS 7'h2a
`define ALIM_MOD_IDX_POS 7'h24
`define ALIM_MOD_IDX_NEG 7'h2c
`define ALIM_MOD_IP_FIRST 7'h60
`define ALIM_MOD_IP_LAST 7'h65
`define ALIM_MOD_MP_FIRST 7'h68
`define ALIM_MOD_MP_LAST 7'h6d
// timing
`define ALIM_CLK_NS 100
`define ALIM_FLT_NS 4000
`define ALIM_FLT_CYC ((`ALIM_FLT_NS + `ALIM_CLK_NS - 1) / `ALIM_CLK_NS)
`define ALIM_DEC_CYC 8'h10
`define ALIM_SPEED_RST 16'h0064
// sqrt2 interval scaling: 181/128
`define ALIM_SQ2_NUM 16'h00b5
`define ALIM_SQ2_SH 7
`endif

// ### logic/alim_pkg.sv
`default_nettype none
package alim_pkg;
	typedef enum logic [2:0] {
		ALIM_IDLE,
		ALIM_RUN,
		ALIM_DECEL,
		ALIM_STOPPED
	} alim_state_t;

	// host register port
	typedef struct packed {
		logic [3:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} alim_bus_t;

	// sensor inputs of both axes
	typedef struct packed {
		logic [1:0] plus_el_n_or_p;
		logic [1:0] minus_el_n_or_p;
		logic [1:0] index_in;
		logic [1:0] soft_plus;
		logic [1:0] soft_minus;
		logic [1:0] manual_pulse;
	} alim_sense_t;
endpackage
`default_nettype wire

// ### logic/alim_axis_ctrl.sv
// Operation
// - 20h/28h feed toward plus/minus limit
// - 22h/2Ah feed away from limit
// - logic pin low positive, high negative
// - limit stop bit: immediate or decelerate
// - sub status limits at 12, 13
// - filter drops limit pulses under 4us
// - start on active limit: no pulses
// - feed until either limit turns active; the code ends a feed on the limit it moves toward only
// - leave until both limits inactive; the code ends a leave when the limit it leaves turns inactive
// - 24h/2Ch feed until index count
// - count reached: stop or decelerate
// - index count field holds count minus one
// - host uses constant speed start for index
// - index edge select: falling or rising
// - extended status index at bit 10
// - interpolation codes 60h to 65h
// - 68h to 6Dh follow manual pulses
// - shared interpolation status, same both axes
// - X speed governs linear one, circular
// - synth speed: sqrt2 interval on dual pulse
// - synth speed equals preset speed
//
// Added by the designer: the address map and the strobed register port.
`timescale 1ns/1ns
`default_nettype none
`include "alim_cfg.svh"
module alim_axis_ctrl (
	input wire logic i_core_clk, // 10 MHz reference clock
	input wire logic i_rst, // async reset, active high
	input wire alim_pkg::alim_bus_t i_bus, // register port request
	input wire alim_pkg::alim_sense_t i_sense, // limit, index, manual pulse pins
	input wire logic i_limit_logic_sel, // limit polarity strap
	output logic [31:0] o_rdata, // read data, cycle after strobe
	output logic [1:0] o_pulse, // motor pulse per axis
	output logic [1:0] o_dir_neg, // direction per axis, 1 negative
	output logic [1:0] o_busy // axis running
);
	import alim_pkg::*;

	// filter counter: one per limit input (plus x, plus y, minus x, minus y)
	function automatic logic [7:0] flt_step(input logic raw, input logic held,
		input logic [7:0] cnt);
		flt_step = (raw == held) ? 8'h00 : cnt + 8'h01;
	endfunction

	function automatic logic in_range(input logic [6:0] m, input logic [6:0] lo,
		input logic [6:0] hi);
		in_range = (m >= lo) && (m <= hi);
	endfunction

	logic [31:0] env1_reg [2];
	logic [31:0] env2_reg [2];
	logic [31:0] env3_reg [2];
	logic [31:0] operation_mode_preset_reg [2];
	logic [15:0] speed_reg [2];
	logic [1:0] soft_en_reg;
	alim_state_t state_reg [2];
	logic [3:0] idx_cnt_reg [2];
	logic [1:0] idx_prev_reg;
	logic [1:0] mp_prev_reg;
	logic [15:0] tick_reg [2];
	logic [7:0] dec_reg [2];
	logic [7:0] flt_cnt_reg [4];
	logic [3:0] el_flt_reg;
	logic hs_reg [2];
	logic [31:0] rdata_reg;
	logic [1:0] pulse_reg;
	logic [1:0] dir_reg;
	// busy kept in its own flop so the output never comes from a decoder
	logic [1:0] busy_reg;

	// strap low means active-high limit inputs
	wire [3:0] el_raw = {i_sense.minus_el_n_or_p, i_sense.plus_el_n_or_p} ^
		{4{i_limit_logic_sel}};
	wire [3:0] el_eff;
	wire [1:0] idx_edge;
	wire [1:0] mp_edge;
	wire wr_cmd = i_bus.wr && (i_bus.addr == `ALIM_ADDR_CMD);
	wire [7:0] cmd_code = i_bus.wdata[7:0];
	wire [1:0] cmd_sel = {i_bus.wdata[`ALIM_CMD_Y_AXIS_SELECT], i_bus.wdata[`ALIM_CMD_X_AXIS_SELECT]};
	wire is_start = (cmd_code == `ALIM_CMD_START_FL) || (cmd_code == `ALIM_CMD_START_FL2) ||
		(cmd_code == `ALIM_CMD_START_FH) || (cmd_code == `ALIM_CMD_START_FH2);
	wire is_high = (cmd_code == `ALIM_CMD_START_FH) || (cmd_code == `ALIM_CMD_START_FH2);
	wire is_stop_imm = cmd_code == `ALIM_CMD_STOP_IMM;
	wire is_stop_dec = cmd_code == `ALIM_CMD_STOP_DEC;
	wire [1:0] both_busy = {o_busy[1], o_busy[0]};

	// per-input filter, a level must hold the whole window to pass
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_flt
			wire fen = env1_reg[gi % 2][`ALIM_ENV1_FLTR];
			assign el_eff[gi] = fen ? el_flt_reg[gi] : el_raw[gi];
		end
	endgenerate

	// edge select per axis on the index pin
	assign idx_edge[0] = env2_reg[0][`ALIM_ENV2_EZL] ? (i_sense.index_in[0] & ~idx_prev_reg[0]) :
		(~i_sense.index_in[0] & idx_prev_reg[0]);
	assign idx_edge[1] = env2_reg[1][`ALIM_ENV2_EZL] ? (i_sense.index_in[1] & ~idx_prev_reg[1]) :
		(~i_sense.index_in[1] & idx_prev_reg[1]);
	assign mp_edge = i_sense.manual_pulse & ~mp_prev_reg;

	// per-axis decode of mode and stop conditions
	wire [6:0] mode [2];
	wire [1:0] plus_hit;
	wire [1:0] minus_hit;
	wire [1:0] done_cond;
	wire [1:0] is_ip;
	wire [1:0] is_mp;
	wire [1:0] is_idx;
	wire [1:0] neg_dir;
	wire [1:0] step_now;
	wire ip_shared = is_ip[0] & is_ip[1];
	wire dual_pulse = step_now[0] & step_now[1];
	generate
		for (gi = 0; gi < 2; gi++) begin : g_axis
			assign mode[gi] = operation_mode_preset_reg[gi][6:0];
			// plus and minus side each merge end-limit with soft limit
			assign plus_hit[gi] = el_eff[gi] | (soft_en_reg[gi] & i_sense.soft_plus[gi]);
			assign minus_hit[gi] = el_eff[gi + 2] | (soft_en_reg[gi] & i_sense.soft_minus[gi]);
			assign is_idx[gi] = (mode[gi] == `ALIM_MOD_IDX_POS) || (mode[gi] == `ALIM_MOD_IDX_NEG);
			assign is_ip[gi] = in_range(mode[gi], `ALIM_MOD_IP_FIRST, `ALIM_MOD_IP_LAST) ||
				in_range(mode[gi], `ALIM_MOD_MP_FIRST, `ALIM_MOD_MP_LAST);
			assign is_mp[gi] = in_range(mode[gi], `ALIM_MOD_MP_FIRST, `ALIM_MOD_MP_LAST);
			assign neg_dir[gi] = (mode[gi] == `ALIM_MOD_TO_MINUS) ||
				(mode[gi] == `ALIM_MOD_OFF_PLUS) || (mode[gi] == `ALIM_MOD_IDX_NEG) ||
				(is_ip[gi] && operation_mode_preset_reg[gi][`ALIM_OPERATION_MODE_PRESET_IPNEG]);
			// feed ends on the limit it moves toward; leave ends when the limit it leaves clears
			assign done_cond[gi] =
				(mode[gi] == `ALIM_MOD_TO_PLUS) ? plus_hit[gi] :
				(mode[gi] == `ALIM_MOD_TO_MINUS) ? minus_hit[gi] :
				(mode[gi] == `ALIM_MOD_OFF_MINUS) ? ~minus_hit[gi] :
				(mode[gi] == `ALIM_MOD_OFF_PLUS) ? ~plus_hit[gi] : 1'b0;
			// linear one and circular pace both axes from X speed
			// manual pulse modes step on the pulse edge instead
			assign step_now[gi] = is_mp[gi] ? mp_edge[gi] :
				(tick_reg[(is_ip[gi] && (mode[gi][1:0] != 2'h2) && (mode[gi][2:0] != 3'h3)) ?
				0 : gi] == 16'h0000);
		end
	endgenerate

	// interval stretched by sqrt2 when both axes pulse together
	function automatic logic [15:0] reload(input logic [15:0] base, input logic stretch);
		logic [31:0] prod;
		prod = {16'h0000, base} * {16'h0000, `ALIM_SQ2_NUM};
		reload = stretch ? prod[`ALIM_SQ2_SH +: 16] : base;
	endfunction

	// filters and edge history
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			for (int k = 0; k < 4; k++) begin
				flt_cnt_reg[k] <= 8'h00;
			end
			el_flt_reg <= 4'h0;
			idx_prev_reg <= 2'h0;
			mp_prev_reg <= 2'h0;
		end else begin
			for (int k = 0; k < 4; k++) begin
				flt_cnt_reg[k] <= flt_step(el_raw[k], el_flt_reg[k], flt_cnt_reg[k]);
				if (flt_cnt_reg[k] >= 8'(`ALIM_FLT_CYC - 1)) begin
					el_flt_reg[k] <= el_raw[k];
				end
			end
			idx_prev_reg <= i_sense.index_in;
			mp_prev_reg <= i_sense.manual_pulse;
		end
	end

	// register writes
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			for (int a = 0; a < 2; a++) begin
				env1_reg[a] <= 32'h00000000;
				env2_reg[a] <= 32'h00000000;
				env3_reg[a] <= 32'h00000000;
				operation_mode_preset_reg[a] <= 32'h00000000;
				speed_reg[a] <= `ALIM_SPEED_RST;
			end
			soft_en_reg <= 2'h0;
		end else if (i_bus.wr) begin
			for (int a = 0; a < 2; a++) begin
				if (i_bus.wdata[`ALIM_CMD_X_AXIS_SELECT + a] || i_bus.addr == `ALIM_ADDR_SOFT) begin
					case (i_bus.addr)
						`ALIM_ADDR_ENV1: env1_reg[a] <= i_bus.wdata;
						`ALIM_ADDR_ENV2: env2_reg[a] <= i_bus.wdata;
						`ALIM_ADDR_ENV3: env3_reg[a] <= i_bus.wdata;
						`ALIM_ADDR_OPERATION_MODE_PRESET: operation_mode_preset_reg[a] <= i_bus.wdata;
						`ALIM_ADDR_SPEED: speed_reg[a] <= i_bus.wdata[31:16];
						`ALIM_ADDR_SOFT: soft_en_reg <= i_bus.wdata[1:0];
						default: ;
					endcase
				end
			end
		end
	end

	// axis sequencers
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			for (int a = 0; a < 2; a++) begin
				state_reg[a] <= ALIM_IDLE;
				idx_cnt_reg[a] <= 4'h0;
				tick_reg[a] <= 16'h0000;
				dec_reg[a] <= 8'h00;
				hs_reg[a] <= 1'b0;
			end
			pulse_reg <= 2'h0;
			dir_reg <= 2'h0;
			busy_reg <= 2'h0;
		end else begin
			for (int a = 0; a < 2; a++) begin
				pulse_reg[a] <= 1'b0;
				dir_reg[a] <= neg_dir[a];
				tick_reg[a] <= (tick_reg[a] == 16'h0000) ?
					reload(speed_reg[a], dual_pulse && operation_mode_preset_reg[a][`ALIM_OPERATION_MODE_PRESET_CONSTANT_SYNTH_SPEED_ENABLE] && ip_shared &&
					(mode[a][1:0] != 2'h2) && (mode[a][2:0] != 3'h3)) :
					tick_reg[a] - 16'h0001;
				case (state_reg[a])
					ALIM_IDLE, ALIM_STOPPED: begin
						// a start only reaches the axes selected in the command
						if (wr_cmd && is_start && cmd_sel[a]) begin
							idx_cnt_reg[a] <= 4'h0;
							hs_reg[a] <= is_high;
							// a start on an already met end produces no pulse
							state_reg[a] <= done_cond[a] ? ALIM_STOPPED : ALIM_RUN;
							// busy follows the state on the same edge, so it never lags
							busy_reg[a] <= !done_cond[a];
						end
					end
					ALIM_RUN: begin
						if (wr_cmd && cmd_sel[a] && is_stop_imm) begin
							state_reg[a] <= ALIM_STOPPED;
							busy_reg[a] <= 1'b0;
						end else if (wr_cmd && cmd_sel[a] && is_stop_dec) begin
							state_reg[a] <= ALIM_DECEL;
							dec_reg[a] <= `ALIM_DEC_CYC;
						end else if (done_cond[a] || (is_idx[a] && idx_edge[a] &&
							idx_cnt_reg[a] == env3_reg[a][`ALIM_ENV3_EZD_LO +: 4])) begin
							// limit stop chooses immediate or decelerated
							// index end: constant speed stops, high speed decelerates
							// high speed start overruns the index edge
							if ((is_idx[a] && hs_reg[a]) ||
								(!is_idx[a] && env1_reg[a][`ALIM_ENV1_ELM])) begin
								state_reg[a] <= ALIM_DECEL;
								dec_reg[a] <= `ALIM_DEC_CYC;
							end else begin
								state_reg[a] <= ALIM_STOPPED;
								busy_reg[a] <= 1'b0;
							end
						end else begin
							// count index edges toward the target
							if (is_idx[a] && idx_edge[a]) begin
								idx_cnt_reg[a] <= idx_cnt_reg[a] + 4'h1;
							end
							// pace from the preset speed interval
							pulse_reg[a] <= step_now[a];
						end
					end
					ALIM_DECEL: begin
						// an immediate stop cuts a running deceleration short
						if (wr_cmd && cmd_sel[a] && is_stop_imm) begin
							state_reg[a] <= ALIM_STOPPED;
							busy_reg[a] <= 1'b0;
						end else begin
							pulse_reg[a] <= step_now[a];
							dec_reg[a] <= dec_reg[a] - 8'h01;
							if (dec_reg[a] == 8'h01) begin
								state_reg[a] <= ALIM_STOPPED;
								busy_reg[a] <= 1'b0;
							end
						end
					end
					default: begin
						state_reg[a] <= ALIM_IDLE;
						busy_reg[a] <= 1'b0;
					end
				endcase
			end
		end
	end

	// read mux: shared interpolation status is identical for either selector
	wire rd_axis = i_bus.wdata[`ALIM_CMD_Y_AXIS_SELECT];
	wire [31:0] ssts_word = (32'(plus_hit[rd_axis]) << `ALIM_SSTS_PEL) |
		(32'(minus_hit[rd_axis]) << `ALIM_SSTS_MEL);
	wire [31:0] extended_status_register_word = 32'(i_sense.index_in[rd_axis]) << `ALIM_EXTENDED_STATUS_REGISTER_EZ;
	// one word built from both axes, not per axis
	wire [31:0] ips_word = {24'h000000, 2'h0, ip_shared, is_mp[0] | is_mp[1], 2'h0, both_busy};
	wire [31:0] rd_mux =
		// limit states in the sub status word
		(i_bus.addr == `ALIM_ADDR_SSTS) ? ssts_word :
		// index pin state in the extended status
		(i_bus.addr == `ALIM_ADDR_EXTENDED_STATUS_REGISTER) ? extended_status_register_word :
		(i_bus.addr == `ALIM_ADDR_IPS) ? ips_word :
		(i_bus.addr == `ALIM_ADDR_OPERATION_MODE_PRESET) ? operation_mode_preset_reg[rd_axis] : 32'h00000000;

	// read data registered, valid one cycle after the strobe only
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			rdata_reg <= 32'h00000000;
		end else begin
			rdata_reg <= i_bus.rd ? rd_mux : 32'h00000000;
		end
	end

	assign o_rdata = rdata_reg;
	assign o_pulse = pulse_reg;
	assign o_dir_neg = dir_reg;
	// set on entry to run, cleared on every path into stopped or idle
	assign o_busy = busy_reg;
endmodule
`default_nettype wire

// ### verif/alim_sva.sv
`timescale 1ns/1ns
`default_nettype none
module alim_sva (
	input wire logic i_core_clk, // reference clock
	input wire logic i_rst, // async reset
	input wire alim_pkg::alim_bus_t i_bus, // register port
	input wire alim_pkg::alim_sense_t i_sense, // sensor pins
	input wire logic i_limit_logic_sel, // limit polarity
	input wire logic [31:0] o_rdata, // read data
	input wire logic [1:0] o_pulse, // step pulses
	input wire logic [1:0] o_dir_neg, // direction
	input wire logic [1:0] o_busy // axis running
);
	import alim_pkg::*;
	logic [7:0] calm_reg;
	logic [7:0] calm_next;
	logic [3:0] snap_reg;
	// x pins: plus, minus, index, strap
	wire [3:0] pins = {i_sense.plus_el_n_or_p[0], i_sense.minus_el_n_or_p[0],
		i_sense.index_in[0], i_limit_logic_sel};
	wire cmd_x = i_bus.wr && i_bus.addr == 4'h4 && i_bus.wdata[8];
	wire rd_x = i_bus.rd && !i_bus.wdata[9];
	assign calm_next = (snap_reg != pins) ? 8'h0 : calm_reg + {7'h0, calm_reg != 8'hff};
	// status is judged only once the pins sat still past the input filter
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			calm_reg <= 8'h0;
			snap_reg <= 4'h0;
		end else begin
			calm_reg <= calm_next;
			snap_reg <= pins;
		end
	end
	default clocking dc @(posedge i_core_clk);
	endclocking
	default disable iff (i_rst);
	sequence halt_s;
		!o_busy[0];
	endsequence
	sequence quiet_s;
		!o_pulse[0] [*4];
	endsequence
	AST_SUB_STATUS_LIMITS: assert property (
		rd_x && i_bus.addr == 4'h6 && calm_reg > 8'h3c |=> o_rdata[13:12] ==
		($past({pins[2], pins[3]}) ^ {2{$past(pins[0])}})) else $error("limit status wrong");
	AST_INDEX_STATE: assert property (
		rd_x && i_bus.addr == 4'h7 && calm_reg > 8'h3c |=> o_rdata[10] == $past(pins[1]))
		else $error("index status wrong");
	AST_STOP_IMMEDIATE: assert property (
		cmd_x && i_bus.wdata[7:0] == 8'h49 |=> halt_s ##1 quiet_s)
		else $error("immediate stop kept running");
	AST_STOP_DECEL: assert property (
		cmd_x && i_bus.wdata[7:0] == 8'h4a |-> ##[1:24] halt_s)
		else $error("decelerating stop too long");
	AST_PULSE_NEEDS_RUN: assert property (
		o_pulse[0] |-> $past(o_busy[0])) else $error("pulse while idle");
	AST_START_NEEDS_CMD: assert property (
		$rose(o_busy[0]) |-> $past(cmd_x)) else $error("run without command");
	AST_PULSE_SINGLE: assert property (
		o_pulse[0] |=> !o_pulse[0]) else $error("pulse longer than a cycle");
	AST_READ_ONE_CYCLE: assert property (
		!$past(i_bus.rd) |-> o_rdata == 32'h0) else $error("read data outside slot");
endmodule
bind alim_axis_ctrl alim_sva u_alim_sva (.i_core_clk(i_core_clk), .i_rst(i_rst),
	.i_bus(i_bus), .i_sense(i_sense), .i_limit_logic_sel(i_limit_logic_sel),
	.o_rdata(o_rdata), .o_pulse(o_pulse), .o_dir_neg(o_dir_neg), .o_busy(o_busy));
`default_nettype wire

// ### verif/alim_partner.sv
`timescale 1ns/1ns
`default_nettype none
module alim_partner #(
	parameter int PLUS_AT = 200,
	parameter int MINUS_AT = -200
) (
	input wire logic i_core_clk, // reference clock
	input wire logic i_rst, // async reset
	input wire logic i_pulse, // x step from the block
	input wire logic i_dir_neg, // x direction, 1 negative
	input wire logic i_logic_sel, // limit polarity strap
	input wire logic i_glitch, // short false plus limit
	output logic o_plus_el, // raw plus end-limit pin
	output logic o_minus_el, // raw minus end-limit pin
	output logic o_index, // index, active high
	output logic signed [15:0] o_pos // position in steps
);
	// one step per pulse; sensors follow position, not time
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			o_pos <= 16'sh0;
		end else if (i_pulse) begin
			o_pos <= i_dir_neg ? o_pos - 16'sh1 : o_pos + 16'sh1;
		end
	end
	// raw pin level flips with the strap
	assign o_plus_el = ((o_pos >= PLUS_AT) | i_glitch) ^ i_logic_sel;
	assign o_minus_el = (o_pos <= MINUS_AT) ^ i_logic_sel;
	// index high on one step in eight, so edges sit at fixed places
	assign o_index = (o_pos[2:0] == 3'h4);
endmodule
`default_nettype wire

// ### verif/tb_axis_limit_index_interp_modes.sv
`timescale 1ns/1ns
`default_nettype none
module tb_axis_limit_index_interp_modes;
	import alim_pkg::*;
	typedef struct packed {
		logic [6:0] mode;
		logic [3:0] ezd;
		logic index_edge_select;
		logic sel;
		logic signed [15:0] pos;
	} alim_row_t;
	logic i_core_clk = 1'b0;
	logic i_rst = 1'b1;
	logic lsel = 1'b0;
	logic glitch = 1'b0;
	alim_bus_t bus = '0;
	alim_sense_t sense;
	logic [31:0] o_rdata, q, qy;
	logic [1:0] o_pulse, o_dir_neg, o_busy;
	logic px, mx, ix;
	logic [6:0] code;
	logic signed [15:0] pos;
	alim_row_t r;
	int err_total = 0;
	int checked = 0;
	int npx, npy;
	logic [7:0] stops [2] = '{8'h49, 8'h4a};
	// each row starts where the previous one stopped
	alim_row_t rows [10] = '{
		'{7'h24, 4'h0, 1'b1, 1'b0, 16'sh4},
		'{7'h24, 4'h2, 1'b0, 1'b0, 16'sh15},
		'{7'h2c, 4'hf, 1'b1, 1'b0, -16'sh64},
		'{7'h2c, 4'h0, 1'b0, 1'b0, -16'sh65},
		'{7'h28, 4'h0, 1'b0, 1'b0, -16'shc8},
		'{7'h22, 4'h0, 1'b0, 1'b0, -16'shc7},
		'{7'h22, 4'h0, 1'b0, 1'b0, -16'shc7},
		'{7'h20, 4'h0, 1'b0, 1'b1, 16'shc8},
		'{7'h20, 4'h0, 1'b0, 1'b1, 16'shc8},
		'{7'h2a, 4'h0, 1'b0, 1'b1, 16'shc7}};
	always #50 i_core_clk = ~i_core_clk;
	// y limits held inactive at the strap level
	assign sense = '{plus_el_n_or_p: {lsel, px}, minus_el_n_or_p: {lsel, mx},
		index_in: {1'b0, ix}, soft_plus: 2'h0, soft_minus: 2'h0, manual_pulse: 2'h0};
	alim_axis_ctrl u_alim_axis_ctrl (.i_core_clk(i_core_clk), .i_rst(i_rst),
		.i_bus(bus), .i_sense(sense), .i_limit_logic_sel(lsel), .o_rdata(o_rdata),
		.o_pulse(o_pulse), .o_dir_neg(o_dir_neg), .o_busy(o_busy));
	alim_partner u_alim_partner (.i_core_clk(i_core_clk), .i_rst(i_rst),
		.i_pulse(o_pulse[0]), .i_dir_neg(o_dir_neg[0]), .i_logic_sel(lsel),
		.i_glitch(glitch), .o_plus_el(px), .o_minus_el(mx), .o_index(ix), .o_pos(pos));
	// bus cycles: one strobe cycle, read data taken in the next
	task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
		@(posedge i_core_clk);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge i_core_clk);
		bus <= '0;
	endtask
	task automatic rd_reg(input logic [3:0] a, input logic y, output logic [31:0] d);
		@(posedge i_core_clk);
		bus <= '{addr: a, wdata: {22'h0, y, 9'h0}, wr: 1'b0, rd: 1'b1};
		@(posedge i_core_clk);
		bus <= '0;
		@(negedge i_core_clk);
		d = o_rdata;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic stop_test();
		$display("checks %0d, errors %0d", checked, err_total);
		if (err_total == 0 && checked > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	// a hung axis counts as a mismatch and ends the run
	task automatic wait_idle();
		int n;
		n = 0;
		repeat (2) @(posedge i_core_clk);
		while (o_busy !== 2'h0 && n < 20000) begin
			@(posedge i_core_clk);
			n++;
		end
		if (n >= 20000) begin
			err_total++;
			stop_test();
		end
	endtask
	// main sequence
	initial begin
		repeat (3) @(posedge i_core_clk);
		i_rst <= 1'b0;
		@(negedge i_core_clk);
		chk({28'h0, o_busy, o_pulse}, 32'h0);
		rd_reg(4'hf, 1'b0, q);
		chk(q, 32'h0);
		wr_reg(4'h0, 32'h100);
		wr_reg(4'h5, 32'h0010_0100);
		foreach (rows[i]) begin
			r = rows[i];
			@(posedge i_core_clk);
			lsel <= r.sel;
			wr_reg(4'h1, {8'h0, r.index_edge_select, 14'h0, 1'b1, 8'h0});
			wr_reg(4'h2, {23'h0, 1'b1, r.ezd, 4'h0});
			wr_reg(4'h3, {23'h0, 1'b1, 1'b0, r.mode});
			wr_reg(4'h4, 32'h150);
			wait_idle();
			repeat (64) @(posedge i_core_clk);
			chk({16'h0, pos}, {16'h0, r.pos});
			rd_reg(4'h6, 1'b0, q);
			chk({30'h0, q[13:12]}, {30'h0, pos <= -16'shc8, pos >= 16'shc8});
			rd_reg(4'h7, 1'b0, q);
			chk({31'h0, q[10]}, {31'h0, pos[2:0] == 3'h4});
			chk({31'h0, o_dir_neg[0]}, {31'h0, r.mode[3]});
		end
		// short false limit: hidden with the filter on, seen without it
		wr_reg(4'h0, 32'h0400_0100);
		glitch <= 1'b1;
		rd_reg(4'h6, 1'b0, q);
		repeat (12) @(posedge i_core_clk);
		rd_reg(4'h6, 1'b0, q);
		@(posedge i_core_clk);
		glitch <= 1'b0;
		chk({31'h0, q[12]}, 32'h0);
		wr_reg(4'h0, 32'h100);
		glitch <= 1'b1;
		repeat (12) @(posedge i_core_clk);
		rd_reg(4'h6, 1'b0, q);
		@(posedge i_core_clk);
		glitch <= 1'b0;
		chk({31'h0, q[12]}, 32'h1);
		// decelerating limit stop runs past the limit
		wr_reg(4'h0, 32'h108);
		wr_reg(4'h5, 32'h0003_0100);
		wr_reg(4'h3, 32'h120);
		wr_reg(4'h4, 32'h150);
		wait_idle();
		chk({31'h0, pos > 16'shc8}, 32'h1);
		// stop commands in mid-run
		wr_reg(4'h2, 32'h1f0);
		wr_reg(4'h3, 32'h12c);
		foreach (stops[i]) begin
			wr_reg(4'h4, 32'h150);
			repeat (10) @(posedge i_core_clk);
			wr_reg(4'h4, {24'h1, stops[i]});
			repeat (30) @(posedge i_core_clk);
			chk({30'h0, o_busy}, 32'h0);
		end
		// every interpolation code, both axes selected
		for (int m = 0; m < 12; m++) begin
			code = (m < 6) ? 7'h60 + m[6:0] : 7'h62 + m[6:0];
			wr_reg(4'h3, {22'h0, 2'b11, 1'b0, code});
			wr_reg(4'h4, 32'h350);
			rd_reg(4'h8, 1'b0, q);
			rd_reg(4'h8, 1'b1, qy);
			chk(qy, q);
			chk({31'h0, q[4]}, {31'h0, m >= 6});
			chk({31'h0, q[5]}, 32'h1);
			chk({30'h0, q[1:0]}, 32'h3);
			wr_reg(4'h4, 32'h349);
			wait_idle();
		end
		// synth speed on both axes: x interval of 4 cycles stretched by sqrt2 to 5
		wr_reg(4'h3, {16'h0, 1'b1, 5'h0, 2'b11, 1'b0, 7'h61});
		wr_reg(4'h4, 32'h350);
		repeat (10) @(posedge i_core_clk);
		npx = 0;
		npy = 0;
		repeat (100) begin
			@(negedge i_core_clk);
			npx += o_pulse[0];
			npy += o_pulse[1];
		end
		chk(npx, 32'd20);
		chk(npy, 32'd20);
		wr_reg(4'h4, 32'h349);
		wait_idle();
		stop_test();
	end
endmodule
`default_nettype wire
